/* tcrb_checker_assertions.sv */
`default_nettype none
// ************************************************
// port-level watch on the timer block
// ************************************************
module tcrb_checker (
   input wire logic        mclk,
   input wire logic        sys_rst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        power_down,
   input wire logic        timer_irq,
   input wire logic        rx_baud_pulse,
   input wire logic        tx_baud_pulse
);
   // decode of the register window and of a taken control write
   wire logic mapped = paddr inside {tcrb_pkg::ADDR_CTRL, tcrb_pkg::ADDR_RCAP_LOW, tcrb_pkg::ADDR_RCAP_HI,
                                     tcrb_pkg::ADDR_CNT_LOW, tcrb_pkg::ADDR_CNT_HI};
   wire logic ctrl_wr = psel && penable && pready && pwrite && (paddr == tcrb_pkg::ADDR_CTRL);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // a frozen oscillator must hold for two samples before pulses are judged
   sequence access_wait; psel && penable && !pready; endsequence
   sequence answered; pready ##1 !pready; endsequence
   sequence pd_held; power_down ##1 power_down; endsequence
   answer_one_cycle_a: assert property (access_wait |=> answered) else $error("apb answer late");
   unmapped_error_a: assert property ((access_wait and !mapped) |=> pslverr) else $error("no slave error");
   error_with_ready_a: assert property (pslverr |-> pready) else $error("stray slave error");
   upper_bits_zero_a: assert property (prdata[31:8] == 24'h000000) else $error("upper data set");
   irq_held_a: assert property (timer_irq && !ctrl_wr && !$past(ctrl_wr) |=> timer_irq)
      else $error("request dropped alone");
   rx_pulse_single_a: assert property (rx_baud_pulse |=> !rx_baud_pulse) else $error("rx pulse wide");
   tx_pulse_single_a: assert property (tx_baud_pulse |=> !tx_baud_pulse) else $error("tx pulse wide");
   power_quiet_a: assert property (pd_held |-> !rx_baud_pulse && !tx_baud_pulse)
      else $error("pulse while halted");
endmodule
bind tcrb_top tcrb_checker chk_u (.mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .power_down(power_down), .timer_irq(timer_irq), .rx_baud_pulse(rx_baud_pulse),
   .tx_baud_pulse(tx_baud_pulse));
`default_nettype wire

/* tcrb_edge_det.sv */
`default_nettype none
// *************************************************
// falling-edge catcher with two-state transfer
// *************************************************
module tcrb_edge_det (
   input  wire logic mclk,
   input  wire logic sys_rst,
   input  wire logic clk_en,
   input  wire logic pin,
   input  wire logic xfer_stb,
   input  wire logic sync_stb,
   output logic      event_q
);
   logic pin_prev_q;
   logic edge_catch_flop_q;
   logic edge_sync_flop_q;

   // previous pin level; resets high so a pin held low through reset counts as an edge
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pin_prev_q <= 1'b1;
      end else if (clk_en) begin
         pin_prev_q <= pin;
      end
   end

   // catch flop: a new edge wins over the clear done by the transfer
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         edge_catch_flop_q <= 1'b0;
      end else if (clk_en) begin
         if (pin_prev_q && !pin) begin
            edge_catch_flop_q <= 1'b1;
         end else if (xfer_stb) begin
            edge_catch_flop_q <= 1'b0;
         end
      end
   end

   // second flop loads at the transfer state, is consumed at the sync state
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         edge_sync_flop_q <= 1'b0;
         event_q          <= 1'b0;
      end else if (clk_en) begin
         event_q <= sync_stb && edge_sync_flop_q;
         if (xfer_stb) begin
            edge_sync_flop_q <= edge_catch_flop_q;
         end else if (sync_stb) begin
            edge_sync_flop_q <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

/* tcrb_pins_model.sv */
`default_nettype none
// ************************************************
// pin driver and serial-side pulse counter
// ************************************************
module tcrb_pins_model (
   input  wire logic mclk,
   input  wire logic rx_baud_pulse,
   input  wire logic tx_baud_pulse,
   output var logic  external_count_pin,
   output var logic  edge_trigger_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   int rx_cnt = 0;
   int tx_cnt = 0;
   int gap = 0;
   int last_gap = 0;
   // pins idle high like a pulled-up port line
   initial begin
      external_count_pin = 1'b1;
      edge_trigger_pin = 1'b1;
   end
   // the serial side counts clocks; gap exposes the pulse rate
   always @(posedge mclk) begin
      gap <= gap + 1;
      if (rx_baud_pulse) begin
         rx_cnt <= rx_cnt + 1;
         last_gap <= gap + 1;
         gap <= 0;
      end
      if (tx_baud_pulse) tx_cnt <= tx_cnt + 1;
   end
   // one falling edge; each level held twelve clocks, the least the detectors allow
   task automatic pulse(input bit trg);
      @(posedge mclk);
      if (trg) edge_trigger_pin <= 1'b0; else external_count_pin <= 1'b0;
      repeat (12) @(posedge mclk);
      if (trg) edge_trigger_pin <= 1'b1; else external_count_pin <= 1'b1;
      repeat (12) @(posedge mclk);
   endtask
endmodule
`default_nettype wire

/* tcrb_pkg.sv */
// Operation
// RULE1: one 8-bit control register at 0C8H: flags, baud selects, enables, source, mode.
// RULE2: baud selects and capture/reload select all 0 with run set: 16-bit auto-reload.
// RULE3: baud selects 0, capture/reload select 1, run set: 16-bit capture mode.
// RULE4: either baud select 1 gives baud generator with reload; capture select ignored.
// RULE5: run control 0 stops all counting; run control 1 enables it in every mode.
// RULE6: clock source 0 counts internal clock; 1 counts pulses from external count pin.
// RULE7: falling edges on edge trigger pin ignored unless edge input enable is 1.
// RULE8: auto-reload: overflow or enabled trigger edge loads counter from reload pair.
// RULE9: capture: enabled trigger edge copies counter bytes into reload/capture pair.
// RULE10: overflow flag set on carry in auto-reload or capture mode.
// RULE11: external edge flag set on enabled trigger falling edge, in every mode.
// RULE12: both flags form one interrupt request; only software clears them.
// RULE13: in baud mode overflow does not set overflow flag; edge flag still works.
// RULE14: baud overflows clock receive and/or transmit circuit per the two selects.
// RULE15: baud mode internal clock counts at half oscillator; counter reads undefined.
// RULE16: count pin fall caught, moved to second flop at S5, made pulse at S3.
// RULE17: trigger pin fall caught, moved to second flop at S2, made event at S4.
// RULE18: external driver holds each pin level at least twelve oscillator periods.
// RULE19: counter stops while oscillator-halting power-down mode is active.
// RULE20: 16-bit up-counter of two bytes; carry on wrap from all ones to zero.
// RULE21: outside baud mode internal clock increments once per twelve-period machine cycle.
`default_nettype none
package tcrb_pkg;
   // *************************************************
   // register map (byte addresses)
   // *************************************************
   localparam logic [11:0] ADDR_CTRL     = 12'h0C8;
   localparam logic [11:0] ADDR_RCAP_LOW = 12'h0CC;
   localparam logic [11:0] ADDR_RCAP_HI  = 12'h0D0;
   localparam logic [11:0] ADDR_CNT_LOW  = 12'h0D4;
   localparam logic [11:0] ADDR_CNT_HI   = 12'h0D8;
   localparam logic [7:0]  CTRL_RESET    = 8'h00;
   localparam logic [15:0] CNT_RESET     = 16'h0000;
   localparam logic [15:0] CNT_ALL_ONES  = 16'hFFFF;
   // *************************************************
   // control field positions
   // *************************************************
   localparam int BIT_OVF   = 7;
   localparam int BIT_EXF   = 6;
   localparam int BIT_RXB   = 5;
   localparam int BIT_TXB   = 4;
   localparam int BIT_EXEN  = 3;
   localparam int BIT_RUN   = 2;
   localparam int BIT_CSRC  = 1;
   localparam int BIT_CAPRL = 0;
   // *************************************************
   // machine-cycle timing, in oscillator periods
   // *************************************************
   localparam logic [3:0] MC_LAST  = 4'hB;  // twelve periods per machine cycle
   localparam logic [3:0] PH_S2    = 4'h3;  // second half of each state
   localparam logic [3:0] PH_S3    = 4'h5;
   localparam logic [3:0] PH_S4    = 4'h7;
   localparam logic [3:0] PH_S5    = 4'h9;
endpackage
`default_nettype wire

/* tcrb_state_gen.sv */
`default_nettype none
// *************************************************
// machine-cycle state timing from the oscillator
// *************************************************
module tcrb_state_gen (
   input  wire logic mclk,
   input  wire logic sys_rst,
   input  wire logic clk_en,
   input  wire logic osc_halt,
   output logic      mc_tick,
   output logic      half_tick,
   output logic      s2_stb,
   output logic      s3_stb,
   output logic      s4_stb,
   output logic      s5_stb
);
   logic [3:0] phase_q;

   // phase counter stands still while the oscillator is halted
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         phase_q <= 4'h0;
      end else if (clk_en && !osc_halt) begin
         phase_q <= (phase_q == tcrb_pkg::MC_LAST) ? 4'h0 : phase_q + 4'h1;
      end
   end

   // strobes are qualified by the halt so nothing counts during power-down
   assign mc_tick   = !osc_halt && (phase_q == tcrb_pkg::MC_LAST);
   assign half_tick = !osc_halt && phase_q[0];
   assign s2_stb    = !osc_halt && (phase_q == tcrb_pkg::PH_S2);
   assign s3_stb    = !osc_halt && (phase_q == tcrb_pkg::PH_S3);
   assign s4_stb    = !osc_halt && (phase_q == tcrb_pkg::PH_S4);
   assign s5_stb    = !osc_halt && (phase_q == tcrb_pkg::PH_S5);
endmodule
`default_nettype wire

/* tcrb_top.sv */
// The implementer's own choice: register access over APB.
`default_nettype none
// *************************************************
// timer two: reload, capture and baud generator
// *************************************************
module tcrb_top (
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   input  wire logic        clk_en,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        external_count_pin,
   input  wire logic        edge_trigger_pin,
   input  wire logic        power_down,
   output logic             timer_irq,
   output logic             rx_baud_pulse,
   output logic             tx_baud_pulse
);
   logic [7:0]  ctrl_q;
   logic [15:0] cnt_q;
   logic [15:0] rcap_q;
   logic        pready_q;
   logic        pslverr_q;
   logic [31:0] prdata_q;
   logic        irq_q;
   logic        rx_pulse_q;
   logic        tx_pulse_q;

   logic mc_tick;
   logic half_tick;
   logic s2_stb;
   logic s3_stb;
   logic s4_stb;
   logic s5_stb;
   logic count_event;
   logic trig_event;

   // *************************************************
   // timing and pin detectors
   // *************************************************
   tcrb_state_gen u_state (
      .mclk      (mclk),
      .sys_rst   (sys_rst),
      .clk_en    (clk_en),
      .osc_halt  (power_down),
      .mc_tick   (mc_tick),
      .half_tick (half_tick),
      .s2_stb    (s2_stb),
      .s3_stb    (s3_stb),
      .s4_stb    (s4_stb),
      .s5_stb    (s5_stb)
   );

   // count pin: transfer at S5, pulse at S3
   tcrb_edge_det u_count_det (
      .mclk     (mclk),
      .sys_rst  (sys_rst),
      .clk_en   (clk_en),
      .pin      (external_count_pin),
      .xfer_stb (s5_stb),  // RULE16
      .sync_stb (s3_stb),  // RULE16
      .event_q  (count_event)
   );

   // trigger pin: transfer at S2, event at S4
   tcrb_edge_det u_trig_det (
      .mclk     (mclk),
      .sys_rst  (sys_rst),
      .clk_en   (clk_en),
      .pin      (edge_trigger_pin),
      .xfer_stb (s2_stb),  // RULE17
      .sync_stb (s4_stb),  // RULE17
      .event_q  (trig_event)
   );

   // *************************************************
   // mode decode
   // *************************************************
   logic run;
   logic baud_mode;
   logic reload_mode;
   logic capture_mode;
   logic trig_ok;
   logic count_tick;
   logic carry;

   assign run          = ctrl_q[tcrb_pkg::BIT_RUN];
   assign baud_mode    = ctrl_q[tcrb_pkg::BIT_RXB] || ctrl_q[tcrb_pkg::BIT_TXB];  // RULE4
   assign reload_mode  = !baud_mode && !ctrl_q[tcrb_pkg::BIT_CAPRL];              // RULE2
   assign capture_mode = !baud_mode && ctrl_q[tcrb_pkg::BIT_CAPRL];               // RULE3
   assign trig_ok      = trig_event && ctrl_q[tcrb_pkg::BIT_EXEN];                // RULE7

   // source select; internal rate depends on baud mode
   always_comb begin
      if (!run || power_down) begin
         count_tick = 1'b0;  // RULE5 RULE19
      end else if (ctrl_q[tcrb_pkg::BIT_CSRC]) begin
         count_tick = count_event;  // RULE6
      end else if (baud_mode) begin
         count_tick = half_tick;  // RULE15
      end else begin
         count_tick = mc_tick;  // RULE21
      end
   end

   assign carry = count_tick && (cnt_q == tcrb_pkg::CNT_ALL_ONES);  // RULE20

   // *************************************************
   // apb slave: one wait state, answer from flops
   // *************************************************
   logic access;
   logic wr_ctrl;
   logic wr_rcap_lo;
   logic wr_rcap_hi;
   logic wr_cnt_lo;
   logic wr_cnt_hi;
   logic mapped;

   assign access = psel && penable && pready_q;

   always_comb begin
      mapped     = 1'b1;
      wr_ctrl    = 1'b0;
      wr_rcap_lo = 1'b0;
      wr_rcap_hi = 1'b0;
      wr_cnt_lo  = 1'b0;
      wr_cnt_hi  = 1'b0;
      if (paddr == tcrb_pkg::ADDR_CTRL) begin
         wr_ctrl = access && pwrite;  // RULE1
      end else if (paddr == tcrb_pkg::ADDR_RCAP_LOW) begin
         wr_rcap_lo = access && pwrite;
      end else if (paddr == tcrb_pkg::ADDR_RCAP_HI) begin
         wr_rcap_hi = access && pwrite;
      end else if (paddr == tcrb_pkg::ADDR_CNT_LOW) begin
         wr_cnt_lo = access && pwrite;
      end else if (paddr == tcrb_pkg::ADDR_CNT_HI) begin
         wr_cnt_hi = access && pwrite;
      end else begin
         mapped = 1'b0;
      end
   end

   // ready rises one cycle into the access phase and drops after the edge it is seen at
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else if (clk_en) begin
         pready_q  <= psel && penable && !pready_q;
         pslverr_q <= psel && penable && !pready_q && !mapped;
         if (psel && penable && !pready_q && !pwrite) begin
            if (paddr == tcrb_pkg::ADDR_CTRL) begin
               prdata_q <= {24'h00_0000, ctrl_q};
            end else if (paddr == tcrb_pkg::ADDR_RCAP_LOW) begin
               prdata_q <= {24'h00_0000, rcap_q[7:0]};
            end else if (paddr == tcrb_pkg::ADDR_RCAP_HI) begin
               prdata_q <= {24'h00_0000, rcap_q[15:8]};
            end else if (paddr == tcrb_pkg::ADDR_CNT_LOW) begin
               // while counting fast in baud mode this byte may be torn
               prdata_q <= {24'h00_0000, cnt_q[7:0]};  // RULE15
            end else if (paddr == tcrb_pkg::ADDR_CNT_HI) begin
               prdata_q <= {24'h00_0000, cnt_q[15:8]};
            end else begin
               prdata_q <= 32'h0000_0000;
            end
         end
      end
   end

   // *************************************************
   // control register and flags
   // *************************************************
   logic set_ovf;
   logic set_exf;

   assign set_ovf = carry && !baud_mode;  // RULE10 RULE13
   assign set_exf = trig_ok;              // RULE11

   // hardware set wins over a software clear in the same cycle
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         ctrl_q <= tcrb_pkg::CTRL_RESET;
      end else if (clk_en) begin
         if (wr_ctrl) begin
            ctrl_q <= pwdata[7:0];
         end
         if (set_ovf) begin
            ctrl_q[tcrb_pkg::BIT_OVF] <= 1'b1;  // RULE12
         end
         if (set_exf) begin
            ctrl_q[tcrb_pkg::BIT_EXF] <= 1'b1;  // RULE12
         end
      end
   end

   // *************************************************
   // counter and reload/capture pair
   // *************************************************
   // reload on carry (reload and baud) or on enabled trigger (reload only)
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cnt_q <= tcrb_pkg::CNT_RESET;
      end else if (clk_en) begin
         if (wr_cnt_lo) begin
            cnt_q[7:0] <= pwdata[7:0];
         end else if (wr_cnt_hi) begin
            cnt_q[15:8] <= pwdata[7:0];
         end else if (run && ((carry && !capture_mode) || (trig_ok && reload_mode))) begin
            cnt_q <= rcap_q;  // RULE8 RULE4
         end else if (count_tick) begin
            cnt_q <= cnt_q + 16'h0001;  // RULE20
         end
      end
   end

   // capture takes precedence over a software write in the same cycle
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rcap_q <= tcrb_pkg::CNT_RESET;
      end else if (clk_en) begin
         if (run && capture_mode && trig_ok) begin
            rcap_q <= cnt_q;  // RULE9
         end else if (wr_rcap_lo) begin
            rcap_q[7:0] <= pwdata[7:0];
         end else if (wr_rcap_hi) begin
            rcap_q[15:8] <= pwdata[7:0];
         end
      end
   end

   // *************************************************
   // outputs to interrupt controller and serial port
   // *************************************************
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         irq_q      <= 1'b0;
         rx_pulse_q <= 1'b0;
         tx_pulse_q <= 1'b0;
      end else if (clk_en) begin
         irq_q      <= ctrl_q[tcrb_pkg::BIT_OVF] || ctrl_q[tcrb_pkg::BIT_EXF];  // RULE12
         rx_pulse_q <= carry && ctrl_q[tcrb_pkg::BIT_RXB];  // RULE14
         tx_pulse_q <= carry && ctrl_q[tcrb_pkg::BIT_TXB];  // RULE14
      end
   end

   assign prdata        = prdata_q;
   assign pready        = pready_q;
   assign pslverr       = pslverr_q;
   assign timer_irq     = irq_q;
   assign rx_baud_pulse = rx_pulse_q;
   assign tx_baud_pulse = tx_pulse_q;
endmodule
`default_nettype wire

/* timer_counter_reload_capture_baud_bench.sv */
`default_nettype none
// ************************************************
// self-checking bench for the timer block
// ************************************************
module timer_counter_reload_capture_baud_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, power_down = 1'b0;
   logic clk_en = 1'b1;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   logic [31:0] prdata;
   logic        pready, pslverr, ecp, etp, timer_irq, rxp, txp;
   logic [32:0] exp_q[$];
   logic [31:0] lf = 32'hf885;
   logic [11:0] A[5] = '{tcrb_pkg::ADDR_CTRL, tcrb_pkg::ADDR_RCAP_LOW, tcrb_pkg::ADDR_RCAP_HI,
                         tcrb_pkg::ADDR_CNT_LOW, tcrb_pkg::ADDR_CNT_HI};
   int n_fail = 0, cmp_count = 0, n;
   tcrb_top dut_u (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .external_count_pin(ecp), .edge_trigger_pin(etp), .power_down(power_down), .timer_irq(timer_irq),
      .rx_baud_pulse(rxp), .tx_baud_pulse(txp));
   tcrb_pins_model pins_u (.mclk(mclk), .rx_baud_pulse(rxp), .tx_baud_pulse(txp),
      .external_count_pin(ecp), .edge_trigger_pin(etp));
   initial begin
      forever #12.5 mclk = ~mclk;
   end
   task automatic check(input logic [32:0] seen, input logic [32:0] want);
      cmp_count++;
      if (seen !== want) begin
         n_fail++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, seen, want);
      end
   endtask
   task automatic finish_test;
      $display("mismatches %0d comparisons %0d", n_fail, cmp_count);
      if (n_fail == 0 && cmp_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // one apb transfer; a read files its expected answer first
   task automatic apb(input logic [11:0] a, input logic w, input logic [7:0] d, input logic e);
      if (!w) exp_q.push_back({e, 24'h000000, d});
      @(posedge mclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= {24'h000000, d};
      @(posedge mclk);
      penable <= 1'b1;
      // wait for ready at a rising edge; only the watchdog ends a hung wait
      do @(posedge mclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input int i, input logic [7:0] d);
      apb(A[i], 1'b1, d, 1'b0);
   endtask
   task automatic rd(input int i, input logic [7:0] d);
      apb(A[i], 1'b0, d, 1'b0);
   endtask
   // read answers are matched against the oldest note
   always @(posedge mclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) check({pslverr, prdata}, exp_q.pop_front());
   end
   initial begin
      repeat (20000) @(posedge mclk);
      n_fail++;
      finish_test();
   end
   initial begin
      repeat (10) @(posedge mclk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 5; i++) rd(i, 8'h00);
      apb(12'h0E0, 1'b1, 8'hFF, 1'b0);
      apb(12'h0E0, 1'b0, 8'h00, 1'b1);
      repeat (4) begin
         lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
         wr(1, lf[7:0]);
         wr(2, lf[15:8]);
         rd(1, lf[7:0]);
         rd(2, lf[15:8]);
      end
      // 120 enabled clocks give ten machine cycles; 36 frozen clocks add none
      wr(3, 8'h00);
      wr(0, 8'h04);
      repeat (58) @(posedge mclk);
      clk_en <= 1'b0;
      repeat (36) @(posedge mclk);
      clk_en <= 1'b1;
      repeat (58) @(posedge mclk);
      wr(0, 8'h00);
      rd(3, 8'h0A);
      repeat (30) @(posedge mclk);
      rd(3, 8'h0A);
      foreach (A[i]) if (i > 0) wr(i, i[0] ? 8'hFE : 8'hFF);
      wr(0, 8'h04);
      repeat (40) @(posedge mclk);
      rd(0, 8'h84);
      rd(4, 8'hFF);
      check(33'(timer_irq), 33'h1);
      // stop first so no carry can re-set the flag during the clear
      wr(0, 8'h80);
      wr(0, 8'h00);
      repeat (3) @(negedge mclk);
      check(33'(timer_irq), 33'h0);
      wr(3, 8'h00);
      wr(0, 8'h06);
      repeat (3) pins_u.pulse(1'b0);
      rd(3, 8'h03);
      wr(3, 8'h34);
      wr(4, 8'h12);
      wr(0, 8'h07);
      pins_u.pulse(1'b1);
      rd(0, 8'h07);
      wr(0, 8'h0F);
      pins_u.pulse(1'b1);
      rd(0, 8'h4F);
      rd(1, 8'h34);
      rd(2, 8'h12);
      wr(1, 8'hAB);
      wr(2, 8'h00);
      wr(0, 8'h0E);
      pins_u.pulse(1'b1);
      rd(3, 8'hAB);
      rd(4, 8'h00);
      // baud run with capture bit set, which must be ignored
      wr(0, 8'h00);
      foreach (A[i]) if (i > 0) wr(i, i[0] ? 8'hF0 : 8'hFF);
      wr(0, 8'h3D);
      repeat (300) @(posedge mclk);
      pins_u.pulse(1'b1);
      rd(0, 8'h7D);
      rd(1, 8'hF0);
      check(33'(pins_u.rx_cnt >= 9), 33'h1);
      check(33'(pins_u.last_gap), 33'd32);
      power_down <= 1'b1;
      repeat (3) @(posedge mclk);
      n = pins_u.rx_cnt;
      repeat (100) @(posedge mclk);
      check(33'(pins_u.rx_cnt), 33'(n));
      power_down <= 1'b0;
      wr(0, 8'h24);
      // let a pulse launched at the write edge be counted first
      repeat (2) @(posedge mclk);
      n = pins_u.tx_cnt;
      repeat (100) @(posedge mclk);
      check(33'(pins_u.tx_cnt), 33'(n));
      finish_test();
   end
endmodule
`default_nettype wire
